/* rtl/icb_pkg.sv */
// package: register map, field encodings and scaling constants for input conditioning
package icb_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 6;
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL     = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_RATIO    = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_OFFSET   = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_FILTER   = 6'h0c;
  localparam logic [ADDR_W-1:0] OFS_EMISS    = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_FULL     = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_LOWER    = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 6'h1c;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 6'h20;
  localparam logic [ADDR_W-1:0] OFS_VALUE    = 6'h24;
  // ctrl fields
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_PV_BIT   = 2;
  localparam int unsigned CTRL_RAD_BIT  = 3;
  // status / mask bits
  localparam int unsigned ST_FAIL_SET   = 0;
  localparam int unsigned ST_FAIL_CLR   = 1;
  localparam int unsigned ST_SAMPLE     = 2;
  localparam int unsigned ST_W          = 3;
  // fixed point: ratio has 3 decimals, emissivity 2 decimals
  localparam int signed RATIO_ONE   = 1000;
  localparam int signed RATIO_MIN   = -20000;
  localparam int signed RATIO_MAX   = 20000;
  localparam int signed OFFSET_MIN  = -999;
  localparam int signed OFFSET_MAX  = 9999;
  localparam int unsigned EMISS_ONE = 100;
  localparam int unsigned EMISS_MIN = 1;
  localparam int unsigned EMISS_MAX = 100;
  localparam int unsigned FILT_MAX  = 120;
  localparam int unsigned VAL_W     = 32;
  localparam int unsigned FRAC_W    = 16;
  // reset values and AXI response codes
  localparam logic signed [15:0] RATIO_RST  = 16'sh03e8;
  localparam logic [6:0]         EMISS_RST  = 7'h64;
  localparam logic [1:0]         RESP_OKAY  = 2'b00;
  localparam logic [1:0]         RESP_SLVERR = 2'b10;
  // sample period and diagnostic blink
  localparam int unsigned SAMPLE_HZ   = 10;
  localparam int unsigned BLINK_SAMPLES = 5;
  typedef enum logic [1:0] {
    ICB_MODE_NONE    = 2'b00,
    ICB_MODE_UP      = 2'b01,
    ICB_MODE_DOWN    = 2'b10,
    ICB_MODE_NO_DET  = 2'b11
  } icb_mode_t;
endpackage : icb_pkg

/* rtl/icb_lag_filter.sv */
// first-order lag filter stage, one update per sample strobe
module icb_lag_filter
  import icb_pkg::*;
#(
  parameter int unsigned W = VAL_W,
  parameter int unsigned F = FRAC_W
) (
  input  wire logic                clk,
  input  wire logic                nrst,
  input  wire logic                step,
  input  wire logic [6:0]          tau_s,
  input  wire logic signed [W-1:0] x,
  output logic signed [W-1:0]      y
);
  localparam int unsigned AW = W + F + 8;
  logic signed [AW-1:0] acc_q, acc_d;
  logic signed [AW-1:0] xs;
  logic signed [AW-1:0] diff;
  logic [15:0]          div;
  always_comb begin
    xs   = AW'(x) <<< F;
    diff = xs - acc_q;
    // gain = ts / tau, with ts = 1/SAMPLE_HZ s
    div  = 16'(tau_s) * 16'(SAMPLE_HZ);
    acc_d = acc_q;
    if (step) begin
      if (tau_s == 7'h00 || div == 16'h0001) begin
        acc_d = xs; // see R3
      end else begin
        acc_d = acc_q + diff / $signed({1'b0, div}); // see R2 see R15
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      acc_q <= '0;
    end else begin
      acc_q <= acc_d;
    end
  end
  assign y = W'(acc_q >>> F);
endmodule : icb_lag_filter

/* rtl/icb_input_cond.sv */
// input conditioning: ratio/bias, lag filter, sensor-break handling, AXI4-Lite registers
// Behaviour
// R1 - conditioned value equals raw value times ratio plus offset
// R2 - lag filter time constant set in whole seconds, 1 to 120
// R3 - time constant zero passes input unfiltered
// R4 - no-burnout mode holds last valid value on sensor failure
// R5 - no-burnout with input as process variable drives failsafe on failure only
// R6 - failure in none, up or down mode raises flashing diagnostic
// R7 - upscale mode forces value to full scale on failure
// R8 - downscale mode forces value to lower range on failure
// R9 - upscale and downscale stay in automatic control using forced value
// R10 - no-detection mode ignores failures and sends no excitation
// R11 - no-detection mode disables thermocouple health monitoring
// R12 - pyrometer inputs get emissivity correction, 0.01 to 1.00
// R13 - ratio accepted from -20.000 to 20.000, three decimals
// R14 - offset accepted from -999 to 9999 engineering units
// R15 - filter adds difference scaled by sample period over time constant
// R16 - ratio and offset before filter and substitution; mode is two bits
//
// The address map and the AXI4-Lite slave port are this design's own decisions.
module icb_input_cond #(
  parameter int unsigned SAMPLE_DIV = 20_000_000
) (
  input  wire logic                       clk,
  input  wire logic                       nrst,
  input  wire logic                       sample_valid,
  input  wire logic signed [31:0]         raw_value,
  input  wire logic                       sensor_fail,
  output logic signed [31:0]              process_variable,
  output logic                            input_failure_diagnostic,
  output logic                            failsafe_active,
  output logic                            auto_control,
  output logic                            burnout_excite,
  output logic                            tc_health_en,
  output logic                            irq,
  input  wire logic [icb_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [icb_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready
);
  import icb_pkg::*;

  // registers
  logic [3:0]         ctrl_q, ctrl_d;
  logic signed [15:0] ratio_q, ratio_d;
  logic signed [15:0] offs_q, offs_d;
  logic [6:0]         tau_q, tau_d;
  logic [6:0]         emis_q, emis_d;
  logic signed [31:0] full_q, full_d;
  logic signed [31:0] lower_q, lower_d;
  logic [ST_W-1:0]    st_q, st_d;
  logic [ST_W-1:0]    mask_q, mask_d;
  // axi
  logic               aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
  logic [ADDR_W-1:0]  awa_q, awa_d;
  logic [31:0]        wd_q, wd_d;
  logic [3:0]         ws_q, ws_d;
  logic [31:0]        rd_q, rd_d;
  logic [1:0]         br_q, br_d, rr_q, rr_d;
  // datapath
  logic               s1_q, s2_q, f1_q, f2_q;
  logic signed [31:0] x1_q, x2_q;
  logic signed [31:0] pv_q, pv_d;
  logic               fail_q, fail_d;
  logic               diag_q, diag_d, fs_q, fs_d, irq_q, irq_d;
  logic [7:0]         blink_q, blink_d;
  logic [31:0]        div_q, div_d;
  logic               step;
  logic signed [31:0] scaled, filt;
  logic signed [63:0] prod;
  icb_mode_t          mode;
  logic [ST_W-1:0]    ev;
  logic               wr_go;
  logic [31:0]        wmerge;

  // sensor-side pins cross two flops before use
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      f1_q <= 1'b0;
      f2_q <= 1'b0;
      x1_q <= '0;
      x2_q <= '0;
    end else begin
      s1_q <= sample_valid;
      s2_q <= s1_q;
      f1_q <= sensor_fail;
      f2_q <= f1_q;
      x1_q <= raw_value;
      x2_q <= x1_q;
    end
  end

  assign mode = icb_mode_t'(ctrl_q[CTRL_MODE_LSB +: 2]); // see R16

  // scaling: raw*ratio/1000 + offset, then emissivity
  always_comb begin
    prod   = 64'(x2_q) * 64'(ratio_q) / 64'(RATIO_ONE); // see R1
    prod   = prod + 64'(offs_q); // see R1 see R16
    if (ctrl_q[CTRL_RAD_BIT]) begin
      prod = prod * $signed(64'(emis_q)) / $signed(64'(EMISS_ONE)); // see R12
    end
    scaled = 32'(prod);
  end

  // filter runs on a fixed sample tick so ts/tau is exact
  always_comb begin
    div_d = (div_q == SAMPLE_DIV - 1) ? '0 : div_q + 32'h0000_0001;
  end
  assign step = (div_q == SAMPLE_DIV - 1);

  icb_lag_filter #(
    .W (VAL_W),
    .F (FRAC_W)
  ) u_filt (
    .clk   (clk),
    .nrst  (nrst),
    .step  (step),
    .tau_s (tau_q),
    .x     (scaled),
    .y     (filt)
  );

  // sensor-break substitution
  always_comb begin
    fail_d  = f2_q && (mode != ICB_MODE_NO_DET); // see R10
    pv_d    = pv_q;
    diag_d  = 1'b0;
    fs_d    = 1'b0;
    blink_d = blink_q;
    if (s2_q || step) begin
      blink_d = (blink_q == 8'(2 * BLINK_SAMPLES - 1)) ? 8'h00 : blink_q + 8'h01;
    end
    if (!fail_d) begin
      blink_d = 8'h00;
      pv_d    = filt;
    end else begin
      // intermittent flash: on for half of the blink period
      diag_d = (blink_q < 8'(BLINK_SAMPLES)); // see R6
      unique case (mode)
        ICB_MODE_NONE: begin
          pv_d = pv_q; // see R4
          fs_d = ctrl_q[CTRL_PV_BIT]; // see R5
        end
        ICB_MODE_UP:   pv_d = full_q; // see R7 see R9
        ICB_MODE_DOWN: pv_d = lower_q; // see R8 see R9
        ICB_MODE_NO_DET: pv_d = filt;
      endcase
    end
  end

  // events: failure set, failure cleared, sample taken
  always_comb begin
    ev = '0;
    ev[ST_FAIL_SET] = fail_d && !fail_q;
    ev[ST_FAIL_CLR] = !fail_d && fail_q;
    ev[ST_SAMPLE]   = s2_q;
  end

  // axi write path
  always_comb begin
    aw_d  = aw_q;
    w_d   = w_q;
    awa_d = awa_q;
    wd_d  = wd_q;
    ws_d  = ws_q;
    bv_d  = bv_q;
    if (s_axi_awvalid && !aw_q && !bv_q) begin
      aw_d  = 1'b1;
      awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_q && !bv_q) begin
      w_d  = 1'b1;
      wd_d = s_axi_wdata;
      ws_d = s_axi_wstrb;
    end
    wr_go = aw_q && w_q && !bv_q;
    if (wr_go) begin
      aw_d = 1'b0;
      w_d  = 1'b0;
      bv_d = 1'b1;
    end
    if (bv_q && s_axi_bready) begin
      bv_d = 1'b0;
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  // register file
  always_comb begin
    ctrl_d  = ctrl_q;
    ratio_d = ratio_q;
    offs_d  = offs_q;
    tau_d   = tau_q;
    emis_d  = emis_q;
    full_d  = full_q;
    lower_d = lower_q;
    mask_d  = mask_q;
    st_d    = st_q;
    br_d    = br_q;
    wmerge  = '0;
    if (wr_go) begin
      br_d = RESP_OKAY;
      unique case (awa_q)
        OFS_CTRL: begin
          wmerge = merge(32'(ctrl_q), wd_q, ws_q);
          ctrl_d = wmerge[3:0];
        end
        OFS_RATIO: begin
          wmerge = merge(32'(ratio_q), wd_q, ws_q);
          // out-of-range settings are refused, old value stays
          if ($signed(wmerge) >= RATIO_MIN && $signed(wmerge) <= RATIO_MAX) begin
            ratio_d = 16'(wmerge); // see R13
          end else begin
            br_d = RESP_SLVERR;
          end
        end
        OFS_OFFSET: begin
          wmerge = merge(32'(offs_q), wd_q, ws_q);
          if ($signed(wmerge) >= OFFSET_MIN && $signed(wmerge) <= OFFSET_MAX) begin
            offs_d = 16'(wmerge); // see R14
          end else begin
            br_d = RESP_SLVERR;
          end
        end
        OFS_FILTER: begin
          wmerge = merge(32'(tau_q), wd_q, ws_q);
          if (wmerge <= FILT_MAX) begin
            tau_d = 7'(wmerge); // see R2
          end else begin
            br_d = RESP_SLVERR;
          end
        end
        OFS_EMISS: begin
          wmerge = merge(32'(emis_q), wd_q, ws_q);
          if (wmerge >= EMISS_MIN && wmerge <= EMISS_MAX) begin
            emis_d = 7'(wmerge); // see R12
          end else begin
            br_d = RESP_SLVERR;
          end
        end
        OFS_FULL:     full_d  = merge(full_q, wd_q, ws_q);
        OFS_LOWER:    lower_d = merge(lower_q, wd_q, ws_q);
        OFS_STATUS:   st_d    = st_q & ~wd_q[ST_W-1:0];
        OFS_IRQ_MASK: mask_d  = wd_q[ST_W-1:0];
        OFS_VALUE:    br_d    = RESP_OKAY;
        default:      br_d    = RESP_SLVERR;
      endcase
    end
    // a new event wins over a clear in the same cycle
    st_d  = st_d | ev;
    irq_d = |(st_d & mask_d);
  end

  // axi read path
  always_comb begin
    rv_d = rv_q;
    rd_d = rd_q;
    rr_d = rr_q;
    if (s_axi_arvalid && !rv_q) begin
      rv_d = 1'b1;
      rr_d = RESP_OKAY;
      unique case (s_axi_araddr)
        OFS_CTRL:     rd_d = 32'(ctrl_q);
        OFS_RATIO:    rd_d = 32'(ratio_q);
        OFS_OFFSET:   rd_d = 32'(offs_q);
        OFS_FILTER:   rd_d = 32'(tau_q);
        OFS_EMISS:    rd_d = 32'(emis_q);
        OFS_FULL:     rd_d = full_q;
        OFS_LOWER:    rd_d = lower_q;
        OFS_STATUS:   rd_d = 32'(st_q);
        OFS_IRQ_MASK: rd_d = 32'(mask_q);
        OFS_VALUE:    rd_d = pv_q;
        default: begin
          rd_d = '0;
          rr_d = RESP_SLVERR;
        end
      endcase
    end else if (rv_q && s_axi_rready) begin
      rv_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_q  <= '0;
      ratio_q <= RATIO_RST;
      offs_q  <= '0;
      tau_q   <= '0;
      emis_q  <= EMISS_RST;
      full_q  <= '0;
      lower_q <= '0;
      st_q    <= '0;
      mask_q  <= '0;
      aw_q    <= 1'b0;
      w_q     <= 1'b0;
      awa_q   <= '0;
      wd_q    <= '0;
      ws_q    <= '0;
      bv_q    <= 1'b0;
      br_q    <= RESP_OKAY;
      rv_q    <= 1'b0;
      rd_q    <= '0;
      rr_q    <= RESP_OKAY;
      pv_q    <= '0;
      fail_q  <= 1'b0;
      diag_q  <= 1'b0;
      fs_q    <= 1'b0;
      irq_q   <= 1'b0;
      blink_q <= '0;
      div_q   <= '0;
    end else begin
      ctrl_q  <= ctrl_d;
      ratio_q <= ratio_d;
      offs_q  <= offs_d;
      tau_q   <= tau_d;
      emis_q  <= emis_d;
      full_q  <= full_d;
      lower_q <= lower_d;
      st_q    <= st_d;
      mask_q  <= mask_d;
      aw_q    <= aw_d;
      w_q     <= w_d;
      awa_q   <= awa_d;
      wd_q    <= wd_d;
      ws_q    <= ws_d;
      bv_q    <= bv_d;
      br_q    <= br_d;
      rv_q    <= rv_d;
      rd_q    <= rd_d;
      rr_q    <= rr_d;
      pv_q    <= pv_d;
      fail_q  <= fail_d;
      diag_q  <= diag_d;
      fs_q    <= fs_d;
      irq_q   <= irq_d;
      blink_q <= blink_d;
      div_q   <= div_d;
    end
  end

  // excitation and health enable follow the mode
  logic excite_q, health_q, auto_q;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      excite_q <= 1'b0;
      health_q <= 1'b0;
      auto_q   <= 1'b0;
    end else begin
      excite_q <= (mode != ICB_MODE_NO_DET); // see R10
      health_q <= (mode != ICB_MODE_NO_DET); // see R11
      auto_q   <= !fs_d; // see R9
    end
  end

  assign process_variable         = pv_q;
  assign input_failure_diagnostic = diag_q;
  assign failsafe_active          = fs_q;
  assign auto_control             = auto_q;
  assign burnout_excite           = excite_q;
  assign tc_health_en             = health_q;
  assign irq                      = irq_q;
  assign s_axi_awready            = !aw_q && !bv_q;
  assign s_axi_wready             = !w_q && !bv_q;
  assign s_axi_bvalid             = bv_q;
  assign s_axi_bresp              = br_q;
  assign s_axi_arready            = !rv_q;
  assign s_axi_rvalid             = rv_q;
  assign s_axi_rdata              = rd_q;
  assign s_axi_rresp              = rr_q;
endmodule : icb_input_cond

/* testbench/icb_input_cond_assertions.sv */
// checker: port-level properties of input conditioning
module icb_input_cond_chk #(
  parameter int unsigned SAMPLE_DIV = 20_000_000
) (
  input logic        clk,
  input logic        nrst,
  input logic        sensor_fail,
  input logic        input_failure_diagnostic,
  input logic        failsafe_active,
  input logic        auto_control,
  input logic        burnout_excite,
  input logic        tc_health_en,
  input logic        irq,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready
);
  logic [31:0] lo_run_q;
  logic [31:0] lo_run_d;
  logic [3:0]  w_age_q;
  logic [3:0]  w_age_d;
  // upper bound on a blink dark phase, in clocks, with margin over its 5 blink ticks
  localparam logic [31:0] DARK_MAX = 32'(12 * SAMPLE_DIV + 8);

  always_comb begin
    lo_run_d = (sensor_fail && burnout_excite && !input_failure_diagnostic) ?
               lo_run_q + 32'h1 : 32'h0;
    w_age_d = (s_axi_wvalid && s_axi_wready) ? 4'h0 :
              (w_age_q == 4'hf) ? w_age_q : w_age_q + 4'h1;
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      lo_run_q <= 32'h0;
      w_age_q <= 4'hf;
    end else begin
      lo_run_q <= lo_run_d;
      w_age_q <= w_age_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wr_ans;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence

  property p_excite_pair;
    burnout_excite == tc_health_en;
  endproperty
  property p_nodet_quiet;
    !burnout_excite && !$past(burnout_excite) |-> !input_failure_diagnostic && !failsafe_active;
  endproperty
  property p_fs_auto;
    failsafe_active |-> !auto_control;
  endproperty
  property p_auto_why;
    $fell(auto_control) |-> failsafe_active;
  endproperty
  property p_fs_cause;
    $rose(failsafe_active) |-> $past(sensor_fail, 3) && burnout_excite;
  endproperty
  property p_diag_cause;
    $rose(input_failure_diagnostic) |-> $past(sensor_fail, 3) || $past(sensor_fail, 4);
  endproperty
  property p_diag_live;
    lo_run_q < DARK_MAX;
  endproperty
  property p_wr_resp;
    s_wr_take |=> s_wr_ans;
  endproperty
  property p_rd_resp;
    s_rd_take |=> s_axi_rvalid;
  endproperty
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_irq_fall;
    $fell(irq) |-> w_age_q < 4'h4;
  endproperty

  a_excite_pair: assert property (p_excite_pair)
    else $error("excite and health disagree");
  a_nodet_quiet: assert property (p_nodet_quiet)
    else $error("report with detection off");
  a_fs_auto: assert property (p_fs_auto)
    else $error("failsafe in auto");
  a_auto_why: assert property (p_auto_why)
    else $error("auto left without failsafe");
  a_fs_cause: assert property (p_fs_cause)
    else $error("failsafe without failure");
  a_diag_cause: assert property (p_diag_cause)
    else $error("diagnostic without failure");
  a_diag_live: assert property (p_diag_live)
    else $error("diagnostic dark too long");
  a_wr_resp: assert property (p_wr_resp)
    else $error("late write response");
  a_rd_resp: assert property (p_rd_resp)
    else $error("late read data");
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped");
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped");
  a_irq_fall: assert property (p_irq_fall)
    else $error("irq fell without write");
endmodule : icb_input_cond_chk

bind icb_input_cond icb_input_cond_chk #(.SAMPLE_DIV(SAMPLE_DIV)) u_chk (
  .clk, .nrst, .sensor_fail, .input_failure_diagnostic, .failsafe_active, .auto_control,
  .burnout_excite, .tc_health_en, .irq, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready
);

/* testbench/icb_sensor_model.sv */
// sensor front end model
module icb_sensor_model (
  input  wire logic               clk,
  input  wire logic signed [31:0] level,
  input  wire logic               broken,
  input  wire logic [7:0]         gap,
  output logic                    sample_valid,
  output logic signed [31:0]      raw_value,
  output logic                    sensor_fail
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt = 8'h0;

  always @(posedge clk) begin
    cnt <= (cnt >= gap) ? 8'h0 : cnt + 8'h1;
    sample_valid <= (cnt == 8'h0);
    sensor_fail <= broken;
    // an open sensor reads noise
    raw_value <= broken ? ~raw_value : level;
  end
endmodule : icb_sensor_model

/* testbench/test_input_conditioning_burnout.sv */
// self-checking bench for the input conditioning block
module test_input_conditioning_burnout;
  import icb_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned SDIV = 8;
  logic               clk = 1'b0;
  logic               nrst = 1'b0;
  logic signed [31:0] level = 32'sh0;
  logic               broken = 1'b0;
  logic [7:0]         gap = 8'h3;
  int                 seed = 32'h92661ec5;
  int                 err_total = 0;
  int                 comparisons = 0;
  logic [33:0]        q_e[$];
  logic [33:0]        q_m[$];
  logic [1:0]         q_b[$];
  logic [33:0]        mon_m;
  logic               sample_valid, sensor_fail, input_failure_diagnostic, failsafe_active;
  logic               auto_control, burnout_excite, tc_health_en, irq;
  logic signed [31:0] raw_value, process_variable;
  logic [5:0]         s_axi_awaddr = 6'h0;
  logic [5:0]         s_axi_araddr = 6'h0;
  logic [31:0]        s_axi_wdata = 32'h0;
  logic [3:0]         s_axi_wstrb = 4'hf;
  logic               s_axi_awvalid = 1'b0;
  logic               s_axi_wvalid = 1'b0;
  logic               s_axi_bready = 1'b0;
  logic               s_axi_arvalid = 1'b0;
  logic               s_axi_rready = 1'b0;
  logic               s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]         s_axi_bresp, s_axi_rresp;
  logic [31:0]        s_axi_rdata;

  always #2.5 clk = ~clk;

  icb_sensor_model fe (.clk, .level, .broken, .gap, .sample_valid, .raw_value, .sensor_fail);
  icb_input_cond #(.SAMPLE_DIV(SDIV)) dut (
    .clk, .nrst, .sample_valid, .raw_value, .sensor_fail, .process_variable,
    .input_failure_diagnostic, .failsafe_active, .auto_control, .burnout_excite,
    .tc_health_en, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );

  task automatic report_and_stop();
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [33:0] s, input logic [33:0] e);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // tasks open on an edge: back-to-back calls never drive twice in a step
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] e);
    int n;
    @(posedge clk);
    q_b.push_back(e);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 40) begin
      err_total++;
      report_and_stop();
    end
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [33:0] e, input logic [33:0] m,
                    output logic [31:0] d);
    int n;
    @(posedge clk);
    q_e.push_back(e);
    q_m.push_back(m);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
    if (n == 40) begin
      err_total++;
      report_and_stop();
    end
  endtask : rd

  task automatic rx(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, {2'b00, e}, {34{1'b1}}, d);
  endtask : rx

  always @(posedge clk) begin
    if (s_axi_rvalid && s_axi_rready && q_e.size() > 0) begin
      mon_m = q_m.pop_front();
      chk("read", {s_axi_rresp, s_axi_rdata} & mon_m, q_e.pop_front() & mon_m);
    end
    if (s_axi_bvalid && s_axi_bready && q_b.size() > 0) chk("bresp", s_axi_bresp, q_b.pop_front());
  end

  initial begin
    int          i;
    int          v;
    int          e;
    logic [31:0] d;
    logic [3:0]  cf;
    logic [1:0]  md;
    logic        seen;
    logic [5:0]  ba[7] = '{OFS_RATIO, OFS_RATIO, OFS_OFFSET, OFS_OFFSET, OFS_FILTER,
                           OFS_EMISS, OFS_EMISS};
    int          bd[7] = '{20001, -20001, 10000, -1000, 121, 0, 101};
    int          ra[4] = '{500, -20000, 20000, 1000};
    int          oa[4] = '{15, 9999, -999, 0};
    int          fv[3] = '{300, 5000, -100};
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    rx(OFS_CTRL, 32'h0);
    rx(OFS_RATIO, 32'h3e8);
    rx(OFS_EMISS, 32'h64);
    rx(OFS_IRQ_MASK, 32'h0);
    rd(6'h28, {RESP_SLVERR, 32'h0}, {34{1'b1}}, d);
    wr(6'h3c, 32'h1, RESP_SLVERR);
    wr(OFS_VALUE, 32'h5, RESP_OKAY);
    for (i = 0; i < 7; i++) wr(ba[i], bd[i], RESP_SLVERR);
    rx(OFS_RATIO, 32'h3e8);
    rx(OFS_OFFSET, 32'h0);
    wr(OFS_FILTER, 32'h78, RESP_OKAY);
    rx(OFS_FILTER, 32'h78);
    wr(OFS_FILTER, 32'h0, RESP_OKAY);
    for (i = 0; i < 4; i++) begin
      wr(OFS_RATIO, ra[i], RESP_OKAY);
      wr(OFS_OFFSET, oa[i], RESP_OKAY);
      v = ($random(seed) % 500) * 2;
      gap <= 8'(($random(seed) & 15) + 1);
      level <= v;
      cyc(40);
      e = v * ra[i] / 1000 + oa[i];
      rx(OFS_VALUE, e);
      chk("pv", process_variable, e);
    end
    wr(OFS_EMISS, 32'h32, RESP_OKAY);
    wr(OFS_CTRL, 32'h8, RESP_OKAY);
    cyc(40);
    rx(OFS_VALUE, v / 2);
    wr(OFS_CTRL, 32'h0, RESP_OKAY);
    level <= 1000;
    cyc(40);
    rx(OFS_VALUE, 32'd1000);
    wr(OFS_FILTER, 32'h1, RESP_OKAY);
    level <= 2000;
    cyc(24);
    rd(OFS_VALUE, 34'h0, 34'h0, d);
    chk("lag_mid", $signed(d) > 1050 && $signed(d) < 1400, 1'b1);
    cyc(1600);
    rd(OFS_VALUE, 34'h0, 34'h0, d);
    chk("lag_end", $signed(d) >= 1995 && $signed(d) <= 2000, 1'b1);
    wr(OFS_FILTER, 32'h0, RESP_OKAY);
    wr(OFS_FULL, 32'd5000, RESP_OKAY);
    wr(OFS_LOWER, -32'sd100, RESP_OKAY);
    wr(OFS_IRQ_MASK, 32'h1, RESP_OKAY);
    // last pass: mode 0, no pv bit, no failsafe
    for (i = 0; i < 5; i++) begin
      cf = (i < 4) ? (4'(i) | 4'h4) : 4'h0;
      md = cf[1:0];
      wr(OFS_CTRL, {28'h0, cf}, RESP_OKAY);
      level <= 9000;
      cyc(30);
      chk("fs_range", failsafe_active, 1'b0);
      chk("excite", burnout_excite, md != 2'd3);
      chk("health", tc_health_en, md != 2'd3);
      level <= 300;
      cyc(30);
      broken <= 1'b1;
      cyc(10);
      chk("failsafe", failsafe_active, cf == 4'h4);
      chk("auto", auto_control, cf != 4'h4);
      seen = 1'b0;
      repeat (120) begin
        @(posedge clk);
        if (input_failure_diagnostic) seen = 1'b1;
      end
      chk("diag", seen, md != 2'd3);
      if (md != 2'd3) rx(OFS_VALUE, fv[md]);
      chk("irq_on", irq, md != 2'd3);
      wr(OFS_IRQ_MASK, 32'h0, RESP_OKAY);
      cyc(2);
      chk("irq_mask", irq, 1'b0);
      wr(OFS_IRQ_MASK, 32'h1, RESP_OKAY);
      wr(OFS_STATUS, 32'h7, RESP_OKAY);
      cyc(2);
      chk("irq_clr", irq, 1'b0);
      broken <= 1'b0;
      cyc(10);
      chk("fs_end", failsafe_active, 1'b0);
      rd(OFS_STATUS, {32'h0, md != 2'd3, 1'b0}, 34'h300000003, d);
      wr(OFS_STATUS, 32'h7, RESP_OKAY);
    end
    report_and_stop();
  end
endmodule : test_input_conditioning_burnout
